// ### verilog/hubcfg_pkg.sv
/*
 * Constants shared by the hub configuration register bank: register
 * offsets, built-in default values, configuration mode codes and the
 * timing counts of the hardware reset recovery.
 * Assumes a single 250 MHz core clock.
 */
package hubcfg_pkg;

    // Core clock rate
    localparam int CLK_MHZ = 250;

    // Register offsets
    localparam logic [7:0] OFS_BUS_POWERED_MAX_POWER = 8'h0D;
    localparam logic [7:0] OFS_CTRL_CURRENT_SELF     = 8'h0E;
    localparam logic [7:0] OFS_CTRL_CURRENT_BUS      = 8'h0F;
    localparam logic [7:0] OFS_PORT_POWER_GOOD_DELAY = 8'h10;

    // Hardware reset value of every register
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    // Answer for any unmapped address
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;

    // Units of the budget and delay registers
    localparam int CURRENT_UNIT_MA     = 2;
    localparam int POWER_GOOD_UNIT_MS  = 2;

    // Built-in defaults, 0x32 = 50 units: 100 mA for the budgets, 100 ms for the delay
    localparam logic [7:0] DEF_BUS_POWERED_MAX_POWER = 8'h32;
    localparam logic [7:0] DEF_CTRL_CURRENT_SELF     = 8'h32;
    localparam logic [7:0] DEF_CTRL_CURRENT_BUS      = 8'h32;
    localparam logic [7:0] DEF_PORT_POWER_GOOD_DELAY = 8'h32;

    // Configuration source selected by the mode pins
    localparam logic [1:0] MODE_DEFAULT = 2'h0;
    localparam logic [1:0] MODE_STRAP   = 2'h1;
    localparam logic [1:0] MODE_EEPROM  = 2'h2;
    localparam logic [1:0] MODE_SMBUS   = 2'h3;

    // Recovery time after reset release
    localparam int RECOVERY_US     = 500;
    localparam int RECOVERY_CYCLES = RECOVERY_US * CLK_MHZ;

    // Recovery count at which synchronised straps are captured
    localparam int STRAP_SAMPLE_COUNT = 3;

    // Number of downstream ports and indicators
    localparam int NUM_PORTS = 2;

endpackage : hubcfg_pkg

// ### verilog/hubcfg_sync2.sv
/*
 * Two-flop synchroniser for a bundle of independent level inputs.
 * Assumes each bit is a slow level; no bus coherency is implied.
 */
module hubcfg_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    if (WIDTH < 1) begin : g_bad_width
        $error("hubcfg_sync2: WIDTH must be at least 1");
    end

    // First flop read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : hubcfg_sync2

// ### verilog/hubcfg_delay.sv
/*
 * Recovery delay counter: counts up from reset release and raises done
 * once CYCLES edges have passed. Also reports the running count.
 * Assumes one clock; count freezes when done.
 */
module hubcfg_delay #(
    parameter int CYCLES = 125000,
    parameter int CW     = $clog2(CYCLES + 1)
) (
    input  wire logic          clk,
    input  wire logic          rst,
    output logic [CW-1:0]      count,
    output logic               done
);

    logic [CW-1:0] count_nxt;
    logic          done_nxt;

    if (CYCLES < 1) begin : g_bad_cycles
        $error("hubcfg_delay: CYCLES must be at least 1");
    end

    // Next count, stopping at the limit
    always_comb begin
        count_nxt = count;
        done_nxt  = done;
        if (!done) begin
            count_nxt = count + CW'(1);
            done_nxt  = (count_nxt == CW'(CYCLES));
        end
    end

    // Count register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            done  <= 1'b0;
        end else begin
            count <= count_nxt;
            done  <= done_nxt;
        end
    end

endmodule : hubcfg_delay

// ### verilog/hubcfg_top.sv
/*
 * Hub configuration register bank tail and hardware reset sequencer.
 * Holds the power budget and power-good delay registers, serves loader
 * reads and writes, captures indicator straps after reset, waits out
 * the recovery time, then loads defaults in default or strap mode, or starts the EEPROM fetch in EEPROM mode.
 * Gates port power, transceivers and indicators by state; the oscillator runs from the first clk edge after rst goes low.
 * Assumes rst is a clean image of the reset pin, held long enough by
 * the board; mode and strap pins are asynchronous; the loader and port
 * logic run on clk.
 */
//
// Overview of operation
// - Bus-powered max power register: 8 bits, 2 mA units, 50 means 100 mA.
// - Self-powered controller current: 8 bits, 2 mA units, default 50.
// - Bus-powered controller current: 8 bits, 2 mA units, default 50.
// - Power-good delay register counts 2 ms steps from port power-on.
// - Reads of undefined addresses return zero.
// - Writes to undefined addresses change nothing and raise no error.
// - Default mode loads built-in values into all registers.
// - Strap mode uses strap pins for their subset, defaults elsewhere.
// - Green indicator pins sampled after reset release, used as config.
// - Indicator strapped high drives active low, sinking current.
// - Indicator strapped low drives active high, sourcing current.
// - Reset disables downstream ports and drops port power switches.
// - Reset disables transceivers, differential pairs high impedance.
// - Reset aborts every transaction and keeps no transaction state.
// - Reset returns every register to its reset value, zero for all.
// - Reset halts oscillator and PLL and disables indicators.
// - Device becomes operational 500 us after reset release.
// - Once operational, EEPROM fetch starts only in EEPROM mode.
module hubcfg_top #(
    parameter int RECOVERY_CYCLES = hubcfg_pkg::RECOVERY_CYCLES,
    parameter int NUM_PORTS       = hubcfg_pkg::NUM_PORTS
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [1:0]           cfg_mode_pin,
    input  wire logic [NUM_PORTS-1:0] led_pin_in,
    input  wire logic [NUM_PORTS-1:0] led_on,
    input  wire logic                 cfg_wr_en,
    input  wire logic                 cfg_rd_en,
    input  wire logic [7:0]           cfg_addr,
    input  wire logic [7:0]           cfg_wr_data,
    input  wire logic                 eeprom_done,
    input  wire logic [NUM_PORTS-1:0] port_power_req,
    output logic [7:0]                cfg_rd_data_r,
    output logic                      cfg_rd_valid_r,
    output logic [7:0]                bus_powered_max_power_r,
    output logic [7:0]                controller_current_self_powered_r,
    output logic [7:0]                controller_current_bus_powered_r,
    output logic [7:0]                port_power_good_delay_r,
    output logic [NUM_PORTS-1:0]      downstream_port_power_switch_r,
    output logic [NUM_PORTS-1:0]      port_enable_r,
    output logic                      phy_enable_r,
    output logic                      osc_pll_run_r,
    output logic [NUM_PORTS-1:0]      led_out_r,
    output logic [NUM_PORTS-1:0]      led_oe_r,
    output logic [NUM_PORTS-1:0]      strap_cfg_r,
    output logic                      operational_r,
    output logic                      eeprom_fetch_r
);

    localparam int CW = $clog2(RECOVERY_CYCLES + 1);

    typedef enum logic [1:0] {
        HUBCFG_ST_RECOVER = 2'b00,
        HUBCFG_ST_FETCH   = 2'b01,
        HUBCFG_ST_RUN     = 2'b11
    } hubcfg_state_t;

    if (RECOVERY_CYCLES <= hubcfg_pkg::STRAP_SAMPLE_COUNT) begin : g_bad_rc
        $error("hubcfg_top: RECOVERY_CYCLES too small");
    end
    if (NUM_PORTS < 1) begin : g_bad_np
        $error("hubcfg_top: NUM_PORTS must be >= 1");
    end

    // Register index of an address, 4 when unmapped
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        case (addr)
            hubcfg_pkg::OFS_BUS_POWERED_MAX_POWER: reg_index = 3'h0;
            hubcfg_pkg::OFS_CTRL_CURRENT_SELF:     reg_index = 3'h1;
            hubcfg_pkg::OFS_CTRL_CURRENT_BUS:      reg_index = 3'h2;
            hubcfg_pkg::OFS_PORT_POWER_GOOD_DELAY: reg_index = 3'h3;
            default:                               reg_index = 3'h4;
        endcase
    endfunction : reg_index

    logic [1:0]           mode_sync;
    logic [NUM_PORTS-1:0] led_sync;
    logic [CW-1:0]        rec_count;
    logic                 rec_done;

    // Mode and strap pins come from outside the clock domain
    hubcfg_sync2 #(.WIDTH(2)) u_mode_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (cfg_mode_pin),
        .sync_out (mode_sync)
    );

    hubcfg_sync2 #(.WIDTH(NUM_PORTS)) u_led_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (led_pin_in),
        .sync_out (led_sync)
    );

    // Time from reset release to operational
    hubcfg_delay #(.CYCLES(RECOVERY_CYCLES), .CW(CW)) u_recovery (
        .clk   (clk),
        .rst   (rst),
        .count (rec_count),
        .done  (rec_done)
    );

    // Sequencer
    hubcfg_state_t        state_r;
    hubcfg_state_t        state_nxt;
    logic [1:0]           mode_r;
    logic [1:0]           mode_nxt;
    logic [NUM_PORTS-1:0] strap_r;
    logic [NUM_PORTS-1:0] strap_nxt;
    logic                 strap_taken_r;
    logic                 strap_taken_nxt;
    logic                 load_defaults;
    logic                 fetch_nxt;

    // Strap capture and mode latch after release, then state walk
    always_comb begin
        state_nxt       = state_r;
        mode_nxt        = mode_r;
        strap_nxt       = strap_r;
        strap_taken_nxt = strap_taken_r;
        load_defaults   = 1'b0;
        fetch_nxt       = eeprom_fetch_r;
        if (!strap_taken_r &&
            rec_count == CW'(hubcfg_pkg::STRAP_SAMPLE_COUNT)) begin
            strap_nxt       = led_sync;
            mode_nxt        = mode_sync;
            strap_taken_nxt = 1'b1;
        end
        case (state_r)
            HUBCFG_ST_RECOVER: begin
                if (rec_done) begin
                    case (mode_r)
                        hubcfg_pkg::MODE_EEPROM: begin
                            state_nxt = HUBCFG_ST_FETCH;
                            fetch_nxt = 1'b1;
                        end
                        hubcfg_pkg::MODE_SMBUS: begin
                            state_nxt = HUBCFG_ST_RUN;
                        end
                        default: begin
                            load_defaults = 1'b1;
                            state_nxt     = HUBCFG_ST_RUN;
                        end
                    endcase
                end
            end
            HUBCFG_ST_FETCH: begin
                if (eeprom_done) begin
                    fetch_nxt = 1'b0;
                    state_nxt = HUBCFG_ST_RUN;
                end
            end
            HUBCFG_ST_RUN: begin
                fetch_nxt = 1'b0;
            end
            default: begin
                state_nxt = HUBCFG_ST_RECOVER;
                fetch_nxt = 1'b0;
            end
        endcase
    end

    // Sequencer registers; reset discards all progress
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r        <= HUBCFG_ST_RECOVER;
            mode_r         <= hubcfg_pkg::MODE_DEFAULT;
            strap_r        <= '0;
            strap_taken_r  <= 1'b0;
            eeprom_fetch_r <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            mode_r         <= mode_nxt;
            strap_r        <= strap_nxt;
            strap_taken_r  <= strap_taken_nxt;
            eeprom_fetch_r <= fetch_nxt;
        end
    end

    // Register bank
    logic [7:0] max_power_nxt;
    logic [7:0] cur_self_nxt;
    logic [7:0] cur_bus_nxt;
    logic [7:0] pg_delay_nxt;
    logic [7:0] rd_data_nxt;
    logic       rd_valid_nxt;
    logic       access_ok;

    assign access_ok = (state_r != HUBCFG_ST_RECOVER);

    // Writes and reads by address; unmapped ones fall through
    always_comb begin
        max_power_nxt = bus_powered_max_power_r;
        cur_self_nxt  = controller_current_self_powered_r;
        cur_bus_nxt   = controller_current_bus_powered_r;
        pg_delay_nxt  = port_power_good_delay_r;
        rd_data_nxt   = hubcfg_pkg::UNMAPPED_READ;
        rd_valid_nxt  = cfg_rd_en && access_ok;
        if (load_defaults) begin
            max_power_nxt = hubcfg_pkg::DEF_BUS_POWERED_MAX_POWER;
            cur_self_nxt  = hubcfg_pkg::DEF_CTRL_CURRENT_SELF;
            cur_bus_nxt   = hubcfg_pkg::DEF_CTRL_CURRENT_BUS;
            pg_delay_nxt  = hubcfg_pkg::DEF_PORT_POWER_GOOD_DELAY;
        end else if (cfg_wr_en && access_ok) begin
            case (reg_index(cfg_addr))
                3'h0:    max_power_nxt = cfg_wr_data;
                3'h1:    cur_self_nxt  = cfg_wr_data;
                3'h2:    cur_bus_nxt   = cfg_wr_data;
                3'h3:    pg_delay_nxt  = cfg_wr_data;
                default: max_power_nxt = bus_powered_max_power_r;
            endcase
        end
        if (cfg_rd_en && access_ok) begin
            case (reg_index(cfg_addr))
                3'h0:    rd_data_nxt = bus_powered_max_power_r;
                3'h1:    rd_data_nxt = controller_current_self_powered_r;
                3'h2:    rd_data_nxt = controller_current_bus_powered_r;
                3'h3:    rd_data_nxt = port_power_good_delay_r;
                default: rd_data_nxt = hubcfg_pkg::UNMAPPED_READ;
            endcase
        end
    end

    // Register bank flops, all back to reset value on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_powered_max_power_r           <= hubcfg_pkg::REG_RESET_VALUE;
            controller_current_self_powered_r <= hubcfg_pkg::REG_RESET_VALUE;
            controller_current_bus_powered_r  <= hubcfg_pkg::REG_RESET_VALUE;
            port_power_good_delay_r           <= hubcfg_pkg::REG_RESET_VALUE;
            cfg_rd_data_r                     <= hubcfg_pkg::UNMAPPED_READ;
            cfg_rd_valid_r                    <= 1'b0;
        end else begin
            bus_powered_max_power_r           <= max_power_nxt;
            controller_current_self_powered_r <= cur_self_nxt;
            controller_current_bus_powered_r  <= cur_bus_nxt;
            port_power_good_delay_r           <= pg_delay_nxt;
            cfg_rd_data_r                     <= rd_data_nxt;
            cfg_rd_valid_r                    <= rd_valid_nxt;
        end
    end

    // Port, PHY, clock and indicator gating
    logic                 run;
    logic [NUM_PORTS-1:0] pwr_nxt;
    logic [NUM_PORTS-1:0] en_nxt;
    logic [NUM_PORTS-1:0] led_out_nxt;
    logic [NUM_PORTS-1:0] led_oe_nxt;
    logic [NUM_PORTS-1:0] strap_cfg_nxt;
    logic                 defaults_mode;

    assign run           = (state_r == HUBCFG_ST_RUN);
    assign defaults_mode = (mode_r == hubcfg_pkg::MODE_DEFAULT) ||
                           (mode_r == hubcfg_pkg::MODE_STRAP);

    // Ports powered and enabled only when operational
    always_comb begin
        pwr_nxt = port_power_req & {NUM_PORTS{run}};
        en_nxt  = {NUM_PORTS{run}};
    end

    // Indicator polarity set by the captured strap level
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_led
            always_comb begin
                led_oe_nxt[gi]    = run;
                led_out_nxt[gi]   = strap_r[gi] ? ~led_on[gi]
                                                :  led_on[gi];
                strap_cfg_nxt[gi] = strap_r[gi] & defaults_mode;
            end
        end
    endgenerate

    // Output flops; reset holds everything off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            downstream_port_power_switch_r <= '0;
            port_enable_r                  <= '0;
            phy_enable_r                   <= 1'b0;
            osc_pll_run_r                  <= 1'b0;
            led_out_r                      <= '0;
            led_oe_r                       <= '0;
            strap_cfg_r                    <= '0;
            operational_r                  <= 1'b0;
        end else begin
            downstream_port_power_switch_r <= pwr_nxt;
            port_enable_r                  <= en_nxt;
            phy_enable_r                   <= run;
            osc_pll_run_r                  <= 1'b1;
            led_out_r                      <= led_out_nxt;
            led_oe_r                       <= led_oe_nxt;
            strap_cfg_r                    <= strap_cfg_nxt;
            operational_r                  <= rec_done;
        end
    end

endmodule : hubcfg_top

// ### bench/hubcfg_monitor.sv
/*
 * Assertion checker for the hub configuration top module.
 * Assumes it is bound to hubcfg_top; one clock, async high reset.
 */
module hubcfg_monitor #(
    parameter int RECOVERY_CYCLES = 20,
    parameter int NUM_PORTS       = 2
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic [1:0]           cfg_mode_pin,
    input wire logic [NUM_PORTS-1:0] led_pin_in,
    input wire logic [NUM_PORTS-1:0] led_on,
    input wire logic                 cfg_wr_en,
    input wire logic                 cfg_rd_en,
    input wire logic [7:0]           cfg_addr,
    input wire logic [7:0]           cfg_wr_data,
    input wire logic                 eeprom_done,
    input wire logic [7:0]           cfg_rd_data_r,
    input wire logic                 cfg_rd_valid_r,
    input wire logic [7:0]           bus_powered_max_power_r,
    input wire logic [7:0]           controller_current_self_powered_r,
    input wire logic [7:0]           controller_current_bus_powered_r,
    input wire logic [7:0]           port_power_good_delay_r,
    input wire logic [NUM_PORTS-1:0] downstream_port_power_switch_r,
    input wire logic [NUM_PORTS-1:0] port_enable_r,
    input wire logic                 phy_enable_r,
    input wire logic [NUM_PORTS-1:0] led_out_r,
    input wire logic [NUM_PORTS-1:0] led_oe_r,
    input wire logic                 operational_r,
    input wire logic                 eeprom_fetch_r
);
    int   cnt_r;
    int   cnt_nxt;
    logic mapped;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Edges since reset release, saturating
    always_comb begin
        cnt_nxt = (cnt_r < RECOVERY_CYCLES + 2) ? cnt_r + 1 : cnt_r;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Address hits one of the four registers
    assign mapped = cfg_addr >= hubcfg_pkg::OFS_BUS_POWERED_MAX_POWER &&
                    cfg_addr <= hubcfg_pkg::OFS_PORT_POWER_GOOD_DELAY;

    // Steps of the recovery and default load
    sequence s_leave;
        $rose(operational_r);
    endsequence
    sequence s_local_cfg;
        cfg_mode_pin == hubcfg_pkg::MODE_DEFAULT ||
        cfg_mode_pin == hubcfg_pkg::MODE_STRAP;
    endsequence
    sequence s_regs_def;
        bus_powered_max_power_r == hubcfg_pkg::DEF_BUS_POWERED_MAX_POWER &&
        controller_current_self_powered_r == hubcfg_pkg::DEF_CTRL_CURRENT_SELF
        && controller_current_bus_powered_r == hubcfg_pkg::DEF_CTRL_CURRENT_BUS
        && port_power_good_delay_r == hubcfg_pkg::DEF_PORT_POWER_GOOD_DELAY;
    endsequence

    a_off_while_halted: assert property (!operational_r |->
        port_enable_r == '0 && downstream_port_power_switch_r == '0 &&
        !phy_enable_r && led_oe_r == '0) else $error("outputs on early");
    a_recovery_len: assert property (s_leave |->
        cnt_r == RECOVERY_CYCLES + 1) else $error("recovery length");
    a_not_late: assert property (cnt_r == RECOVERY_CYCLES + 2 |->
        operational_r) else $error("late operational");
    a_def_load: assert property (s_leave ##0 s_local_cfg |=> s_regs_def)
        else $error("defaults not loaded");
    a_fetch_start: assert property (s_leave |->
        eeprom_fetch_r == (cfg_mode_pin == hubcfg_pkg::MODE_EEPROM))
        else $error("fetch start wrong");
    a_fetch_end: assert property (eeprom_fetch_r && eeprom_done |=>
        !eeprom_fetch_r) else $error("fetch did not end");
    a_rd_answer: assert property (cfg_rd_en && operational_r |=>
        cfg_rd_valid_r) else $error("read not answered");
    a_unmapped_zero: assert property (cfg_rd_en && operational_r && !mapped
        |=> cfg_rd_data_r == 8'h00) else $error("unmapped read not zero");
    a_rd_old_value: assert property (cfg_rd_en && operational_r &&
        cfg_addr == hubcfg_pkg::OFS_CTRL_CURRENT_BUS |=>
        cfg_rd_data_r == $past(controller_current_bus_powered_r))
        else $error("read data wrong");
    a_write_takes: assert property (cfg_wr_en && operational_r &&
        $past(operational_r) &&
        cfg_addr == hubcfg_pkg::OFS_PORT_POWER_GOOD_DELAY |=>
        port_power_good_delay_r == $past(cfg_wr_data))
        else $error("write not stored");
    a_unmapped_wr: assert property (cfg_wr_en && operational_r &&
        $past(operational_r) && !mapped |=>
        $stable(bus_powered_max_power_r) &&
        $stable(controller_current_self_powered_r) &&
        $stable(controller_current_bus_powered_r) &&
        $stable(port_power_good_delay_r)) else $error("unmapped write hit");
    a_led_polarity: assert property (led_oe_r != '0 |->
        led_out_r == ($past(led_on) ^ led_pin_in)) else $error("led polarity");
endmodule : hubcfg_monitor

bind hubcfg_top hubcfg_monitor #(
    .RECOVERY_CYCLES(RECOVERY_CYCLES),
    .NUM_PORTS      (NUM_PORTS)
) u_mon (.*);

// ### bench/hubcfg_loader_model.sv
/*
 * Behavioural serial configuration store on the loader side.
 * Assumes the bench drives slow; answers fetch with a done pulse.
 */
module hubcfg_loader_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic eeprom_fetch_r,
    input wire logic slow,
    output logic     eeprom_done
);
    timeunit 1ns;
    timeprecision 100ps;

    initial eeprom_done = 1'b0;

    // Fetch seen: wait, then hold done until the edge samples it
    always begin
        @(posedge clk iff (eeprom_fetch_r === 1'b1 && rst === 1'b0));
        repeat (slow ? 30 : 2) @(posedge clk);
        #1 eeprom_done = 1'b1;
        @(posedge clk);
        #1 eeprom_done = 1'b0;
    end
endmodule : hubcfg_loader_model

// ### bench/hubcfg_tb_top.sv
/*
 * Self-checking bench for the hub configuration top module.
 * Assumes the loader model and checker are compiled first.
 */
module hubcfg_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int RC = 20;
    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } hubcfg_row_t;

    logic       clk = 1'b0;
    logic       rst, cfg_wr_en, cfg_rd_en, eeprom_done, slow;
    logic [1:0] cfg_mode_pin, led_pin_in, led_on, port_power_req;
    logic [7:0] cfg_addr, cfg_wr_data, cfg_rd_data_r, rd_d;
    logic [7:0] bus_powered_max_power_r, controller_current_self_powered_r;
    logic [7:0] controller_current_bus_powered_r, port_power_good_delay_r;
    logic [1:0] downstream_port_power_switch_r, port_enable_r;
    logic [1:0] led_out_r, led_oe_r, strap_cfg_r;
    logic       cfg_rd_valid_r, phy_enable_r, osc_pll_run_r;
    logic       operational_r, eeprom_fetch_r;
    logic [31:0] regs_w;
    logic [54:0] outs_w;
    int         failures = 0;
    int         checks_done = 0;
    int         n;
    // Register rows: 200 mA budget, 50 mA, max, 2 ms, two unmapped
    hubcfg_row_t rows [6] = '{
        '{8'h0D, 8'h64, 8'h64}, '{8'h0E, 8'h19, 8'h19},
        '{8'h0F, 8'hFF, 8'hFF}, '{8'h10, 8'h01, 8'h01},
        '{8'h11, 8'hAA, 8'h00}, '{8'h0C, 8'h55, 8'h00}};

    hubcfg_top #(.RECOVERY_CYCLES(RC)) uut (.*);
    hubcfg_loader_model u_loader (.*);

    // Clock and grouped views of the outputs
    always #2 clk = ~clk;
    assign regs_w = {bus_powered_max_power_r, controller_current_self_powered_r,
        controller_current_bus_powered_r, port_power_good_delay_r};
    assign outs_w = {regs_w, cfg_rd_data_r, cfg_rd_valid_r, phy_enable_r,
        downstream_port_power_switch_r, port_enable_r, osc_pll_run_r,
        led_out_r, led_oe_r, strap_cfg_r, operational_r, eeprom_fetch_r};

    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        cfg_wr_en = 1'b1;
        cfg_addr = a;
        cfg_wr_data = d;
        @(posedge clk);
        #1 cfg_wr_en = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        cfg_rd_en = 1'b1;
        cfg_addr = a;
        @(posedge clk);
        #1 cfg_rd_en = 1'b0;
        d = (cfg_rd_valid_r === 1'b1) ? cfg_rd_data_r : 8'hXX;
    endtask : reg_rd

    // Reset with given pins; optional strobes during recovery
    task automatic hw_reset(input logic [1:0] mode, input logic [1:0] leds,
                            input int hold, input bit poke);
        rst = 1'b1;
        cfg_mode_pin = mode;
        led_pin_in = leds;
        repeat (hold) @(posedge clk);
        #1 chk("outputs in reset", 0, outs_w);
        rst = 1'b0;
        cfg_addr = 8'h10;
        cfg_wr_data = 8'h77;
        n = 0;
        while (operational_r !== 1'b1 && n < 40) begin
            cfg_wr_en = poke && n < RC;
            cfg_rd_en = poke && n < RC;
            @(posedge clk);
            #1 n++;
        end
        chk("recovery edges", RC + 1, n);
        @(posedge clk);
        #1;
    endtask : hw_reset

    // Watchdog against a hang
    initial begin
        #20000;
        failures++;
        final_report;
    end

    initial begin
        {rst, cfg_wr_en, cfg_rd_en, slow} = 4'h8;
        {cfg_mode_pin, led_pin_in, led_on, port_power_req} = 8'h00;
        {cfg_addr, cfg_wr_data} = 16'h0000;
        hw_reset(hubcfg_pkg::MODE_DEFAULT, 2'b10, 8, 0);
        chk("default regs", {4{8'h32}}, regs_w);
        chk("strap capture", 2'b10, strap_cfg_r);
        led_on = 2'b01;
        port_power_req = 2'b01;
        @(posedge clk);
        #1 chk("indicator drive", 2'b11, led_out_r);
        chk("ports up", 8'h7F, {downstream_port_power_switch_r,
            port_enable_r, phy_enable_r, led_oe_r, osc_pll_run_r});
        $display("test default mode done");
        foreach (rows[i]) begin
            reg_wr(rows[i].addr, rows[i].wdata);
            reg_rd(rows[i].addr, rd_d);
            chk("register readback", rows[i].exp, rd_d);
        end
        chk("regs after rows", 32'h6419FF01, regs_w);
        $display("test register rows done");
        // Read and write at once: old value returned
        {cfg_wr_en, cfg_rd_en, cfg_addr, cfg_wr_data} = 18'h30E0A;
        @(posedge clk);
        #1 {cfg_wr_en, cfg_rd_en} = 2'b00;
        chk("read beside write", 8'h19, cfg_rd_data_r);
        chk("written beside read", 8'h0A,
            controller_current_self_powered_r);
        $display("test read beside write done");
        // Mid-run reset held 1 us, strap mode
        hw_reset(hubcfg_pkg::MODE_STRAP, 2'b01, 250, 0);
        chk("strap mode regs", {4{8'h32}}, regs_w);
        chk("strap capture 2", 2'b01, strap_cfg_r);
        $display("test strap mode done");
        // Serial store, prompt then slow
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            hw_reset(hubcfg_pkg::MODE_EEPROM, 2'b11, 8, 0);
            chk("fetch started", 1, eeprom_fetch_r);
            chk("strap off", 0, strap_cfg_r);
            n = 0;
            while (eeprom_fetch_r === 1'b1 && n < 60) begin
                @(posedge clk);
                #1 n++;
            end
            chk("fetch ended", 0, eeprom_fetch_r);
        end
        $display("test serial store done");
        // Host mode, strobes during recovery ignored
        hw_reset(hubcfg_pkg::MODE_SMBUS, 2'b11, 8, 1);
        chk("host fetch", 0, eeprom_fetch_r);
        chk("host regs", 0, regs_w);
        $display("test host mode done");
        final_report;
    end
endmodule : hubcfg_tb_top
